//--- async_serial_peer.sv
/*
  remote serial peer: decodes frames from the unit, sends frames to it.
  assumes bit lengths in core_clk cycles are set by the bench.
*/
`timescale 1ns/10ps
module async_serial_peer
(
    input wire logic core_clk,
    input wire logic tx_pin,
    output logic rx_pin,
    input wire logic [15:0] tx_bit,
    input wire logic [15:0] rx_bit,
    input wire logic nine
);
    logic [8:0] got_q[$];
    int frame_err = 0;
    logic [8:0] shreg;
    int nb;

    initial rx_pin = 1'b1; // line idles high

    // receiver: centre sampling of frames from the unit
    initial
    begin
        forever
        begin
            @(negedge tx_pin);
            nb = nine ? 9 : 8;
            repeat (tx_bit / 2) @(posedge core_clk);
            if (tx_pin !== 1'b0)
                frame_err++;
            shreg = '0;
            for (int i = 0; i < nb; i++)
            begin
                repeat (tx_bit) @(posedge core_clk);
                shreg[i] = tx_pin;
            end
            repeat (tx_bit) @(posedge core_clk);
            if (tx_pin !== 1'b1)
                frame_err++;
            got_q.push_back(shreg);
        end
    end

    // sender: lsb first, stop level chosen by caller
    task automatic send(input logic [8:0] w, input logic stop_lvl);
        int n;
        n = nine ? 9 : 8;
        rx_pin <= 1'b0;
        repeat (rx_bit) @(posedge core_clk);
        for (int i = 0; i < n; i++)
        begin
            rx_pin <= w[i];
            repeat (rx_bit) @(posedge core_clk);
        end
        rx_pin <= stop_lvl;
        repeat (rx_bit) @(posedge core_clk);
        rx_pin <= 1'b1;
    endtask
endmodule // async_serial_peer

//--- async_serial_pkg.sv
/*
  package for the asynchronous serial unit: register offsets, field
  positions, reset values and shared types.
  assumes a byte-wide register port with 3-bit addresses.
*/
package async_serial_pkg;
    localparam logic [2:0] STATUS_OFS = 3'h0;
    localparam logic [2:0] DATA_OFS = 3'h1;
    localparam logic [2:0] BAUD_OFS = 3'h2;
    localparam logic [2:0] CTRL_ONE_OFS = 3'h3;
    localparam logic [2:0] CTRL_TWO_OFS = 3'h4;
    localparam logic [2:0] RX_EXT_OFS = 3'h5;
    localparam logic [2:0] TX_EXT_OFS = 3'h6;
    localparam logic [7:0] STATUS_RESET = 8'hC0;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    // control one fields
    localparam int CR1_BIT8_POS = 7;
    localparam int CR1_TX_BIT8_POS = 6;
    localparam int CR1_WORD9_POS = 4;
    localparam int CR1_PAR_EN_POS = 2;
    localparam int CR1_PAR_ODD_POS = 1;
    localparam int CR1_PAR_IRQ_POS = 0;
    // control two fields
    localparam int CR2_TX_EMPTY_EN_POS = 7;
    localparam int CR2_TX_DONE_EN_POS = 6;
    localparam int CR2_RIE_POS = 5;
    localparam int CR2_IDLE_EN_POS = 4;
    localparam int CR2_TE_POS = 3;
    localparam int CR2_RE_POS = 2;
    localparam int CR2_SBK_POS = 0;
    // baud select fields: common [7:6], tx [5:3], rx [2:0]
    localparam int BAUD_COMMON_POS = 6;
    localparam int BAUD_TX_POW_POS = 3;
    localparam int BAUD_RX_POW_POS = 0;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SAMPLE_MID = 4'h7;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic enter_wait;
        logic halt;
        logic cpu_irq_mask;
    } power_t;
endpackage

//--- async_serial_unit.sv
/*
  asynchronous serial unit: register port, two baud generators,
  transmitter with break, receiver with idle, noise and error flags.
  assumes rx_pin is asynchronous and requests arrive on core_clk.
*/
`timescale 1ns/10ps
// Summary of operation
// (R01) word length of 8 or 9 bits chosen by a control one bit
// (R02) transmit line low during every start bit
// (R03) transmit line high during every stop bit
// (R04) idle character is a full frame of ones
// (R05) receiver flags break when a whole frame of zeros arrives
// (R06) after break frames one extra high bit is sent
// (R07) transmitter and receiver each have an independent baud generator
// (R08) wait mode changes nothing; enabled interrupts wake the device
// (R09) halt freezes registers and pauses transfers
// (R10) all events share one interrupt request line
// (R11) request only when event enabled and cpu mask clear
// (R12) per-event enables; receive-full and overrun share one enable
// (R13) enabled interrupt events wake from wait, none from halt
// (R14) tx empty set when holding data moves to the shift register
// (R15) tx empty clears on status access then data write
// (R16) no load into the shift register while tx empty is set
// (R17) status holds eight read-only flags, reset value C0h
// (R18) nonzero rx extended factor divides the by-16 output
// (R19) nonzero tx extended factor divides the by-16 output
// (R20) common prescaler and power-of-two direction dividers 1 to 128
// (R21) bit rate is clock over 16, prescaler and direction divider
// (R22) start edge detect, centre sampling, framing error on low stop
module async_serial_unit
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire async_serial_pkg::reg_req_t req,
    input wire async_serial_pkg::power_t power,
    input wire logic rx_pin,
    output logic [7:0] rdata,
    output logic tx_pin,
    output logic irq,
    output logic wake
);
    import async_serial_pkg::*;

    logic [7:0] status_reg, data_rx_reg, baud_reg, ctrl1_reg, ctrl2_reg;
    logic [7:0] rx_ext_reg, tx_ext_reg, rdata_reg, hold_reg;
    logic status_seen_reg, hold_bit8_reg, wait_reg;
    logic [1:0] rx_sync_reg;
    logic irq_reg, wake_reg;
    logic run;
    // (R09) halt pauses writes, flags and baud ticks; reads still answer
    assign run = ~power.halt;

    // register decode
    wire wr_data = run & req.wr & (req.addr == DATA_OFS);
    wire rd_data = run & req.rd & (req.addr == DATA_OFS);
    wire acc_stat = run & (req.wr | req.rd) & (req.addr == STATUS_OFS);
    wire word9 = ctrl1_reg[CR1_WORD9_POS];
    wire par_en = ctrl1_reg[CR1_PAR_EN_POS];
    wire par_odd = ctrl1_reg[CR1_PAR_ODD_POS];
    wire tx_en = ctrl2_reg[CR2_TE_POS];
    wire rx_en = ctrl2_reg[CR2_RE_POS];
    wire send_break = ctrl2_reg[CR2_SBK_POS];

    // baud ticks: 16x sample rate per direction
    // (R20) common prescaler codes 1, 3, 4, 13
    logic [3:0] common_div;
    always_comb
    begin
        unique case (baud_reg[BAUD_COMMON_POS +: 2])
            2'b00: common_div = 4'h1;
            2'b01: common_div = 4'h3;
            2'b10: common_div = 4'h4;
            2'b11: common_div = 4'hD;
        endcase
    end
    logic [3:0] common_cnt_reg;
    wire common_tick = run & (common_cnt_reg == common_div - 4'h1);
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            common_cnt_reg <= 4'h0;
        else if (run)
            common_cnt_reg <= common_tick ? 4'h0 : common_cnt_reg + 4'h1;
    end

    // (R07) one divider per direction, selected in a generate loop
    wire [1:0] os_tick;
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_baud
            logic [7:0] cnt_reg;
            logic [7:0] lim;
            logic [2:0] pow;
            logic [7:0] ext;
            assign pow = (g == 0) ? baud_reg[BAUD_TX_POW_POS +: 3]
                                  : baud_reg[BAUD_RX_POW_POS +: 3];
            assign ext = (g == 0) ? tx_ext_reg : rx_ext_reg;
            // (R18) (R19) (R21) extended factor replaces power of two
            assign lim = (ext != 8'h00) ? ext - 8'h01
                                        : (8'h01 << pow) - 8'h01;
            assign os_tick[g] = common_tick & (cnt_reg >= lim);
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    cnt_reg <= 8'h00;
                else if (common_tick)
                    cnt_reg <= os_tick[g] ? 8'h00 : cnt_reg + 8'h01;
            end
        end
    endgenerate

    // transmitter: 16 ticks per bit
    logic [3:0] tx_os_reg, tx_bit_reg;
    logic [10:0] tx_shift_reg;
    logic tx_busy_reg, tx_brk_reg, tx_pin_reg, tx_done_set;
    // (R01) word length sets the frame length
    wire [3:0] frame_bits = word9 ? 4'hB : 4'hA; // start+data+stop
    wire tx_bit_end = os_tick[0] & (tx_os_reg == 4'hF);
    // at or past the end, so a word-length change mid-frame still ends it
    wire tx_last = tx_bit_end & (tx_bit_reg >= frame_bits - 4'h1);
    wire tx_empty_flag = status_reg[7];
    // (R16) load only once software cleared the empty flag
    wire tx_load = tx_en & ~tx_busy_reg & ~tx_empty_flag & ~send_break & run;
    wire tx_par = par_odd ^ (^hold_reg) ^ (word9 & hold_bit8_reg);
    wire [8:0] tx_word = {par_en & ~word9 ? tx_par : hold_bit8_reg,
                          word9 | ~par_en ? hold_reg
                                          : {tx_par, hold_reg[6:0]}};
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_busy_reg <= 1'b0;
            tx_os_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 11'h7FF;
            tx_brk_reg <= 1'b0;
        end
        else if (tx_load)
        begin
            // (R02) (R03) start low, data, stop high
            tx_busy_reg <= 1'b1;
            tx_os_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tx_brk_reg <= 1'b0;
            tx_shift_reg <= word9 ? {1'b1, tx_word, 1'b0}
                                  : {2'b11, tx_word[7:0], 1'b0};
        end
        else if (tx_en & ~tx_busy_reg & send_break & run)
        begin
            // (R06) break frame of zeros, stop bit stays high after
            tx_busy_reg <= 1'b1;
            tx_brk_reg <= 1'b1;
            tx_os_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 11'h000;
        end
        else if (tx_busy_reg & os_tick[0])
        begin
            tx_os_reg <= tx_os_reg + 4'h1;
            if (tx_bit_end & tx_last & tx_brk_reg)
            begin
                // (R06) zero frames repeat, then one high bit
                tx_bit_reg <= send_break ? 4'h0 : frame_bits - 4'h1;
                tx_shift_reg <= send_break ? 11'h000 : 11'h7FF;
                tx_brk_reg <= send_break;
            end
            else if (tx_bit_end)
            begin
                tx_bit_reg <= tx_last ? 4'h0 : tx_bit_reg + 4'h1;
                tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                tx_busy_reg <= ~tx_last;
            end
        end
    end
    assign tx_done_set = tx_last & ~tx_brk_reg;
    // (R04) idle line holds ones when no frame runs
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            tx_pin_reg <= 1'b1;
        else
            tx_pin_reg <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
    end

    // receiver
    logic [3:0] rx_os_reg, rx_bit_reg;
    logic [9:0] rx_shift_reg;
    logic rx_busy_reg, rx_prev_reg, rx_noise_reg, idle_armed_reg;
    logic [2:0] rx_votes_reg;
    logic [3:0] idle_cnt_reg, idle_os_reg;
    wire rx_in = rx_sync_reg[1];
    wire rx_tick = os_tick[1] & rx_en;
    // (R22) falling edge starts a frame
    wire rx_start = rx_tick & ~rx_busy_reg & rx_prev_reg & ~rx_in;
    wire rx_mid = rx_tick & rx_busy_reg & (rx_os_reg == SAMPLE_MID);
    wire rx_end = rx_mid & (rx_bit_reg >= frame_bits - 4'h1);
    wire vote = (rx_votes_reg[0] & rx_votes_reg[1]) |
                (rx_votes_reg[1] & rx_votes_reg[2]) |
                (rx_votes_reg[0] & rx_votes_reg[2]);
    wire noisy = (rx_votes_reg != 3'b000) & (rx_votes_reg != 3'b111);
    wire [8:0] rx_word = word9 ? rx_shift_reg[9:1]
                               : {1'b0, rx_shift_reg[9:2]};
    wire rx_par_bad = par_en & ((^rx_word) ^ par_odd ^
                                (~word9 & rx_word[8]));
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_sync_reg <= 2'b11;
            rx_prev_reg <= 1'b1;
            rx_busy_reg <= 1'b0;
            rx_os_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 10'h000;
            rx_votes_reg <= 3'b111;
            rx_noise_reg <= 1'b0;
        end
        else
        begin
            rx_sync_reg <= {rx_sync_reg[0], rx_pin};
            if (rx_tick)
            begin
                rx_prev_reg <= rx_in;
                rx_votes_reg <= {rx_votes_reg[1:0], rx_in};
            end
            if (rx_start)
            begin
                rx_busy_reg <= 1'b1;
                rx_os_reg <= 4'h0;
                rx_bit_reg <= 4'h0;
                rx_noise_reg <= 1'b0;
            end
            else if (rx_tick & rx_busy_reg)
            begin
                rx_os_reg <= rx_os_reg + 4'h1;
                if (rx_mid)
                begin
                    rx_bit_reg <= rx_bit_reg + 4'h1;
                    rx_shift_reg <= {vote, rx_shift_reg[9:1]};
                    rx_noise_reg <= rx_noise_reg | noisy;
                    if (rx_end)
                        rx_busy_reg <= 1'b0;
                end
            end
        end
    end

    // idle: one full frame of ones after activity
    wire idle_hit = rx_tick & ~rx_busy_reg & rx_in & idle_armed_reg &
                    (idle_os_reg == 4'hF) &
                    (idle_cnt_reg == frame_bits - 4'h1);
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idle_cnt_reg <= 4'h0;
            idle_os_reg <= 4'h0;
            idle_armed_reg <= 1'b0;
        end
        else if (rx_end)
        begin
            idle_cnt_reg <= 4'h0;
            idle_os_reg <= 4'h0;
            idle_armed_reg <= 1'b1;
        end
        else if (idle_hit)
            idle_armed_reg <= 1'b0;
        else if (rx_tick & ~rx_busy_reg)
        begin
            idle_os_reg <= idle_os_reg + 4'h1;
            if (idle_os_reg == 4'hF)
                idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    // (R05) break: all data zero and stop low counts as framing error
    wire rx_stop = rx_end & vote;
    wire rx_break = rx_end & ~vote & (rx_word == 9'h000);
    wire rx_full = status_reg[5];

    // status flags: set wins over clear
    // (R15) clear needs a status access first
    logic [7:0] stat_set, stat_clr;
    wire seq_clr = status_seen_reg & rd_data;
    assign stat_set = {1'b0, tx_done_set, rx_end & ~rx_full, idle_hit,
                       rx_end & rx_full, rx_end & (rx_noise_reg | noisy),
                       (rx_end & ~rx_stop) | rx_break, rx_end & rx_par_bad};
    assign stat_clr = {1'b0, status_seen_reg & wr_data, seq_clr,
                       seq_clr, seq_clr, seq_clr, seq_clr, seq_clr};
    wire tx_empty_set = tx_load;
    wire tx_empty_clr = status_seen_reg & wr_data;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            status_reg <= STATUS_RESET;
        else if (run)
        begin
            // (R17) eight flags, tx empty on top
            // (R14) tx empty set on transfer to shift register
            status_reg[7] <= tx_empty_set | (tx_empty_flag & ~tx_empty_clr);
            status_reg[6:0] <= stat_set[6:0] |
                               (status_reg[6:0] & ~stat_clr[6:0]);
        end
    end

    // register writes and sequence tracking, frozen in halt
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl1_reg <= CTRL_RESET;
            ctrl2_reg <= CTRL_RESET;
            baud_reg <= BAUD_RESET;
            rx_ext_reg <= EXT_RESET;
            tx_ext_reg <= EXT_RESET;
            hold_reg <= 8'h00;
            hold_bit8_reg <= 1'b0;
            data_rx_reg <= 8'h00;
            status_seen_reg <= 1'b0;
        end
        else if (run)
        begin
            if (acc_stat)
                status_seen_reg <= 1'b1;
            else if (wr_data | rd_data)
                status_seen_reg <= 1'b0;
            if (rx_end & ~rx_full)
            begin
                data_rx_reg <= rx_word[7:0];
                ctrl1_reg[CR1_BIT8_POS] <= rx_word[8];
            end
            if (req.wr)
            begin
                unique case (req.addr)
                    DATA_OFS:
                    begin
                        hold_reg <= req.wdata;
                        hold_bit8_reg <= ctrl1_reg[CR1_TX_BIT8_POS];
                    end
                    BAUD_OFS: baud_reg <= req.wdata;
                    CTRL_ONE_OFS: ctrl1_reg[6:0] <= req.wdata[6:0];
                    CTRL_TWO_OFS: ctrl2_reg <= req.wdata;
                    RX_EXT_OFS: rx_ext_reg <= req.wdata;
                    TX_EXT_OFS: tx_ext_reg <= req.wdata;
                    default: ;
                endcase
            end
        end
    end

    // read mux: unmapped reads zero
    wire [7:0] rd_mux =
        (req.addr == STATUS_OFS) ? status_reg :
        (req.addr == DATA_OFS) ? data_rx_reg :
        (req.addr == BAUD_OFS) ? baud_reg :
        (req.addr == CTRL_ONE_OFS) ? ctrl1_reg :
        (req.addr == CTRL_TWO_OFS) ? ctrl2_reg :
        (req.addr == RX_EXT_OFS) ? rx_ext_reg :
        (req.addr == TX_EXT_OFS) ? tx_ext_reg : 8'h00;

    // interrupt request
    // (R10) (R12) one line, per-event enables, shared receive enable
    wire irq_any =
        (status_reg[7] & ctrl2_reg[CR2_TX_EMPTY_EN_POS]) |
        (status_reg[6] & ctrl2_reg[CR2_TX_DONE_EN_POS]) |
        ((status_reg[5] | status_reg[3]) & ctrl2_reg[CR2_RIE_POS]) |
        (status_reg[4] & ctrl2_reg[CR2_IDLE_EN_POS]) |
        (status_reg[0] & ctrl1_reg[CR1_PAR_IRQ_POS]);
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            wait_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= req.rd ? rd_mux : 8'h00;
            // (R11) gated by cpu mask
            irq_reg <= irq_any & ~power.cpu_irq_mask;
            // (R08) (R13) wake from wait only, never from halt
            wait_reg <= power.enter_wait ? 1'b1
                      : (wake_reg ? 1'b0 : wait_reg);
            wake_reg <= wait_reg & irq_any & run & ~wake_reg;
        end
    end

    // outputs straight from flops
    assign rdata = rdata_reg;
    assign tx_pin = tx_pin_reg;
    assign irq = irq_reg;
    assign wake = wake_reg;
endmodule // async_serial_unit

//--- async_serial_unit_props.sv
/*
  concurrent checks on the ports of the serial unit.
  assumes it is bound into every instance of the unit, one clock domain.
*/
`timescale 1ns/10ps
module async_serial_unit_props
    import async_serial_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire async_serial_pkg::reg_req_t req,
    input wire async_serial_pkg::power_t power,
    input wire logic rx_pin,
    input wire logic [7:0] rdata,
    input wire logic tx_pin,
    input wire logic irq,
    input wire logic wake
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // half of the shortest bit time, 16 cycles in all
    sequence low_half;
        !tx_pin [*8];
    endsequence
    sequence high_half;
        tx_pin [*8];
    endsequence

    AST_LOW_BIT: assert property ($fell(tx_pin) |-> low_half ##1 low_half)
        else $error("tx line low for less than one bit");
    AST_HIGH_BIT: assert property ($rose(tx_pin) |-> high_half ##1 high_half)
        else $error("tx line high for less than one bit");
    AST_RDATA_QUIET: assert property (!req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (req.rd && req.addr == 3'h7 |=> rdata == 8'h00)
        else $error("unmapped address returned data");
    AST_IRQ_MASKED: assert property (power.cpu_irq_mask |=> !irq)
        else $error("interrupt raised while masked");
    AST_NO_WAKE_HALT: assert property (power.halt |=> !wake)
        else $error("wake raised in halt");
    AST_WAKE_PULSE: assert property (wake |=> !wake)
        else $error("wake longer than one cycle");
    AST_HALT_FREEZE: assert property (power.halt [*3] |=> $stable(tx_pin))
        else $error("tx line moved during halt");
endmodule // async_serial_unit_props

bind async_serial_unit async_serial_unit_props u_props (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .req(req),
    .power(power),
    .rx_pin(rx_pin),
    .rdata(rdata),
    .tx_pin(tx_pin),
    .irq(irq),
    .wake(wake)
);

//--- async_serial_unit_tb_top.sv
/*
  self-checking bench for the serial unit with a remote peer.
  assumes the package offsets and a 125 MHz core clock.
*/
`timescale 1ns/10ps
module async_serial_unit_tb_top;
    import async_serial_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_t req = '0;
    power_t power = '0;
    logic rx_pin;
    logic [7:0] rdata;
    logic tx_pin;
    logic irq;
    logic wake;
    logic nine = 1'b0;
    logic [15:0] tx_bit = 16'h0020;
    logic [15:0] rx_bit = 16'h0030;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    logic [8:0] exp_q[$];
    logic [8:0] v;
    logic [8:0] e9;
    logic [7:0] d;
    logic [7:0] e;
    logic seen;

    always #4 core_clk = ~core_clk;

    async_serial_unit dut (.core_clk(core_clk), .arst_n(arst_n),
        .req(req), .power(power), .rx_pin(rx_pin), .rdata(rdata),
        .tx_pin(tx_pin), .irq(irq), .wake(wake));
    async_serial_peer peer (.core_clk(core_clk), .tx_pin(tx_pin),
        .rx_pin(rx_pin), .tx_bit(tx_bit), .rx_bit(rx_bit), .nine(nine));

    task automatic test_done;
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // register port cycles
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] w);
        @(posedge core_clk);
        req <= {a, w, 1'b1, 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge core_clk);
        req <= {a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 r = rdata;
    endtask

    // poll status until a flag sets, bounded
    task automatic wait_status(input int pos);
        n = 0;
        d = 8'h00;
        while (d[pos] !== 1'b1)
        begin
            reg_rd(STATUS_OFS, d);
            n++;
            if (n > 4000)
            begin
                error_cnt++;
                test_done();
            end
        end
    endtask

    // status access then data write sends one frame
    task automatic tx_word(input logic [8:0] w);
        wait_status(7);
        reg_wr(DATA_OFS, w[7:0]);
        exp_q.push_back(w);
    endtask

    // wait for the peer, then compare against the model queue
    task automatic drain;
        n = 0;
        while (peer.got_q.size() < exp_q.size() && n < 20000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20000)
        begin
            error_cnt++;
            test_done();
        end
        while (exp_q.size() > 0)
        begin
            v = peer.got_q.pop_front();
            e9 = exp_q.pop_front();
            check(v[7:0], e9[7:0]);
            check(8'(v[8]), 8'(e9[8]));
        end
    endtask

    // look at wake for eight cycles from the current edge
    task automatic watch_wake(output logic s);
        s = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            #1 s = s | (wake === 1'b1);
            @(posedge core_clk);
        end
    endtask

    initial
    begin
        void'($urandom(32'hdbbc));
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // reset values, read-only status, unmapped place
        reg_wr(STATUS_OFS, 8'hFF);
        reg_rd(STATUS_OFS, d);
        check(d, STATUS_RESET);
        reg_rd(3'h7, d);
        check(d, 8'h00);
        reg_rd(RX_EXT_OFS, d);
        check(d, EXT_RESET);
        reg_rd(TX_EXT_OFS, d);
        check(d, EXT_RESET);
        for (int i = 0; i < 4; i++)
        begin
            e = 8'($urandom());
            reg_wr(i[0] ? TX_EXT_OFS : RX_EXT_OFS, e);
            reg_rd(i[0] ? TX_EXT_OFS : RX_EXT_OFS, d);
            check(d, e);
        end
        // extended rates: tx 16*2, rx 16*3 cycles
        reg_wr(BAUD_OFS, 8'h00);
        reg_wr(TX_EXT_OFS, 8'h02);
        reg_wr(RX_EXT_OFS, 8'h03);
        reg_wr(CTRL_TWO_OFS, 8'h88);
        repeat (3) @(posedge core_clk);
        #1 check(8'(irq), 8'h01);
        @(posedge core_clk);
        power.cpu_irq_mask <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check(8'(irq), 8'h00);
        @(posedge core_clk);
        power.cpu_irq_mask <= 1'b0;
        // second write without status access must not be sent
        tx_word({1'b0, 8'($urandom())});
        repeat (4) @(posedge core_clk);
        reg_wr(DATA_OFS, 8'($urandom()));
        tx_word({1'b0, 8'($urandom())});
        drain();
        check(8'(peer.got_q.size()), 8'h00);
        // nine-bit frame, ninth bit from control one
        nine = 1'b1;
        reg_wr(CTRL_ONE_OFS, 8'h50);
        tx_word({1'b1, 8'($urandom())});
        drain();
        nine = 1'b0;
        reg_wr(CTRL_ONE_OFS, 8'h00);
        // conventional rate: prescaler 3, divider 2
        reg_wr(TX_EXT_OFS, 8'h00);
        reg_wr(BAUD_OFS, 8'h48);
        tx_bit = 16'd96;
        tx_word({1'b0, 8'($urandom())});
        drain();
        reg_wr(BAUD_OFS, 8'h00);
        // receive: good stop, then low stop
        reg_wr(CTRL_TWO_OFS, 8'h2C);
        for (int i = 0; i < 2; i++)
        begin
            e = 8'($urandom());
            @(posedge core_clk);
            peer.send({1'b0, e}, i == 0);
            wait_status(5);
            check(8'(d[1]), 8'(i));
            check(8'(irq), 8'h01);
            reg_rd(DATA_OFS, d);
            check(d, e);
            reg_rd(STATUS_OFS, d);
            check(8'(d[5]), 8'h00);
        end
        // halt ignores writes but reads still answer
        @(posedge core_clk);
        power.halt <= 1'b1;
        reg_wr(TX_EXT_OFS, 8'h55);
        reg_rd(TX_EXT_OFS, d);
        check(d, 8'h00);
        @(posedge core_clk);
        power.halt <= 1'b0;
        // wait entered in halt: no wake until halt ends, then wake
        reg_wr(CTRL_TWO_OFS, 8'h88);
        @(posedge core_clk);
        power.halt <= 1'b1;
        power.enter_wait <= 1'b1;
        @(posedge core_clk);
        power.enter_wait <= 1'b0;
        watch_wake(seen);
        check(8'(seen), 8'h00);
        power.halt <= 1'b0;
        watch_wake(seen);
        check(8'(seen), 8'h01);
        check(8'(peer.frame_err), 8'h00);
        test_done();
    end
endmodule // async_serial_unit_tb_top
